// ==== inc/tpw_defs.vh ====
// constants for the 16-bit pwm timer block
// assumes a single 40 MHz clock and an axi4-lite master for register access
`ifndef TPW_DEFS_VH
`define TPW_DEFS_VH
`define TPW_OFF_CTRL 8'h00
`define TPW_OFF_CNT 8'h04
`define TPW_OFF_CMPA 8'h08
`define TPW_OFF_CMPB 8'h0C
`define TPW_OFF_CAP 8'h10
`define TPW_OFF_FLAG 8'h14
`define TPW_OFF_DIR 8'h18
`define TPW_CTRL_WGM_LSB 0
`define TPW_CTRL_COMA_LSB 4
`define TPW_CTRL_COMB_LSB 6
`define TPW_CTRL_RST 8'h00
`define TPW_FLG_OVF 0
`define TPW_FLG_CMPA 1
`define TPW_FLG_CMPB 2
`define TPW_FLG_CAP 3
`define TPW_TOP8 16'h00FF
`define TPW_TOP9 16'h01FF
`define TPW_TOP10 16'h03FF
`define TPW_MAX 16'hFFFF
`define TPW_BOTTOM 16'h0000
`define TPW_COM_TOGGLE 2'h1
`define TPW_COM_NONINV 2'h2
`define TPW_COM_INV 2'h3
`define TPW_RESP_OKAY 2'h0
`define TPW_RESP_SLVERR 2'h2
`endif

// ==== logic/tpw_out_unit.v ====
// one compare output unit: buffered compare value, match flag event, waveform level
// assumes counter, direction and wrap come from the timer core on the same clock
`timescale 1ns/1ps
`include "tpw_defs.vh"
module tpw_out_unit (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire tick_i,
	input wire wr_i,
	input wire [15:0] wdata_i,
	input wire [15:0] mask_i,
	input wire load_i,
	input wire buffered_i,
	input wire dual_i,
	input wire up_i,
	input wire wrap_i,
	input wire [1:0] mode_i,
	input wire toggle_ok_i,
	input wire dir_i,
	input wire [15:0] count_i,
	output wire [15:0] active_o,
	output wire [15:0] buffer_o,
	output wire match_o,
	output wire pin_o,
	output wire pin_oe_o
);
	reg [15:0] buf_q;
	reg [15:0] act_q;
	reg level_q;
	wire pwm_on;
	assign match_o = tick_i && (count_i == act_q);
	assign active_o = act_q;
	assign buffer_o = buf_q;
	assign pwm_on = mode_i[1];
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			buf_q <= 16'h0000;
			act_q <= 16'h0000;
			level_q <= 1'b0;
		end else begin
			if (wr_i) begin
				buf_q <= wdata_i & mask_i;
			end
			// unbuffered when no pwm mode is active, so writes land at once
			if (wr_i && !buffered_i) begin
				act_q <= wdata_i & mask_i;
			end else if (tick_i && load_i && buffered_i) begin
				act_q <= buf_q;
			end
			if (pwm_on && !dual_i) begin
				// match wins over wrap so compare at top holds one level
				if (match_o) begin
					level_q <= (mode_i == `TPW_COM_INV);
				end else if (wrap_i) begin
					level_q <= (mode_i == `TPW_COM_NONINV);
				end
			end else if (pwm_on && dual_i) begin
				if (match_o) begin
					level_q <= (mode_i == `TPW_COM_INV) ? up_i : !up_i;
				end
			end else if (mode_i == `TPW_COM_TOGGLE && toggle_ok_i && match_o) begin
				level_q <= !level_q;
			end
		end
	end
	// level only reaches the pin while the direction bit says output
	assign pin_o = level_q;
	assign pin_oe_o = dir_i && (mode_i != 2'h0);
endmodule

// ==== logic/tpw_timer.v ====
// 16-bit timer core for fast and phase correct pwm, with an axi4-lite register slave
// assumes tick_i is a one-cycle enable from an external prescaler on ref_clk_i
`timescale 1ns/1ps
`include "tpw_defs.vh"
module tpw_timer (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire tick_i,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire compare_output_a_o,
	output wire compare_output_a_oe_o,
	output wire compare_output_b_o,
	output wire compare_output_b_oe_o
);
	reg [7:0] ctrl_q;
	reg [15:0] counter_value_q;
	reg [15:0] capture_top_value_q;
	reg [3:0] flags_q;
	reg [1:0] dir_q;
	reg up_q;
	reg [7:0] awaddr_q;
	reg aw_have_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg w_have_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	reg [3:0] flag_set;
	reg [15:0] top;
	reg [15:0] mask;
	reg [15:0] counter_value_d;
	reg up_d;
	reg [31:0] rd_mux;
	reg rd_ok;
	wire [3:0] waveform_mode_select;
	wire [1:0] output_mode_a;
	wire [1:0] output_mode_b;
	wire fast;
	wire dual;
	wire at_top;
	wire at_bottom;
	wire wr_fire;
	wire wr_low;
	wire [15:0] cmp_a_act;
	wire [15:0] cmp_a_buf;
	wire [15:0] cmp_b_buf;
	wire match_a;
	wire match_b;
	wire wrap;
	wire top_is_a;
	wire top_is_cap;
	assign waveform_mode_select = ctrl_q[`TPW_CTRL_WGM_LSB +: 4];
	assign output_mode_a = ctrl_q[`TPW_CTRL_COMA_LSB +: 2];
	assign output_mode_b = ctrl_q[`TPW_CTRL_COMB_LSB +: 2];
	assign fast = (waveform_mode_select == 4'd5) || (waveform_mode_select == 4'd6) ||
		(waveform_mode_select == 4'd7) || (waveform_mode_select == 4'd14) ||
		(waveform_mode_select == 4'd15);
	assign dual = (waveform_mode_select == 4'd1) || (waveform_mode_select == 4'd2) ||
		(waveform_mode_select == 4'd3) || (waveform_mode_select == 4'd10) ||
		(waveform_mode_select == 4'd11);
	assign top_is_a = (waveform_mode_select == 4'd15) || (waveform_mode_select == 4'd11);
	assign top_is_cap = (waveform_mode_select == 4'd14) || (waveform_mode_select == 4'd10);
	// top selection and fixed-width write mask
	always @* begin
		mask = `TPW_MAX;
		case (waveform_mode_select)
			4'd1, 4'd5: begin
				top = `TPW_TOP8;
				mask = `TPW_TOP8;
			end
			4'd2, 4'd6: begin
				top = `TPW_TOP9;
				mask = `TPW_TOP9;
			end
			4'd3, 4'd7: begin
				top = `TPW_TOP10;
				mask = `TPW_TOP10;
			end
			4'd10, 4'd14: top = capture_top_value_q;
			4'd11, 4'd15: top = cmp_a_act;
			default: top = `TPW_MAX;
		endcase
	end
	assign at_top = (fast || dual) && (counter_value_q == top);
	assign at_bottom = (counter_value_q == `TPW_BOTTOM);
	assign wrap = tick_i && fast && at_top;
	// counter next state; only moves on timer enable
	always @* begin
		counter_value_d = counter_value_q;
		up_d = up_q;
		if (tick_i) begin
			if (fast && at_top) begin
				counter_value_d = `TPW_BOTTOM;
			end else if (dual) begin
				if (up_q && at_top) begin
					up_d = 1'b0; // holds top one cycle then reverses
					counter_value_d = counter_value_q - 16'h0001;
				end else if (!up_q && at_bottom) begin
					up_d = 1'b1;
					counter_value_d = counter_value_q + 16'h0001;
				end else if (up_q) begin
					counter_value_d = counter_value_q + 16'h0001;
				end else begin
					counter_value_d = counter_value_q - 16'h0001;
				end
			end else begin
				// top below count just runs through max and wraps
				counter_value_d = counter_value_q + 16'h0001;
			end
			if (dual && at_top && (top == `TPW_BOTTOM)) begin
				counter_value_d = `TPW_BOTTOM;
			end
		end
	end
	// flag events from hardware
	always @* begin
		flag_set = 4'h0;
		flag_set[`TPW_FLG_CMPA] = match_a;
		flag_set[`TPW_FLG_CMPB] = match_b;
		if (tick_i && fast && at_top) begin
			flag_set[`TPW_FLG_OVF] = 1'b1;
			flag_set[`TPW_FLG_CMPA] = match_a || top_is_a;
			flag_set[`TPW_FLG_CAP] = top_is_cap;
		end
		if (tick_i && dual && at_bottom && !up_q) begin
			flag_set[`TPW_FLG_OVF] = 1'b1;
		end
		if (tick_i && dual && at_top && up_q) begin
			flag_set[`TPW_FLG_CMPA] = match_a || top_is_a;
			flag_set[`TPW_FLG_CAP] = top_is_cap;
		end
	end
	// write channel: address and data taken in either order, response after both
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign wr_fire = aw_have_q && w_have_q;
	assign wr_low = wr_fire && wstrb_q[0] && wstrb_q[1];
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ctrl_q <= `TPW_CTRL_RST;
			counter_value_q <= 16'h0000;
			capture_top_value_q <= 16'h0000;
			flags_q <= 4'h0;
			dir_q <= 2'h0;
			up_q <= 1'b1;
			awaddr_q <= 8'h00;
			aw_have_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `TPW_RESP_OKAY;
		end else begin
			counter_value_q <= counter_value_d;
			up_q <= up_d;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_have_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			// set wins over a software clear in the same cycle
			flags_q <= flags_q & ~((wr_fire && awaddr_q == `TPW_OFF_FLAG && wstrb_q[0]) ?
				wdata_q[3:0] : 4'h0) | flag_set;
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= `TPW_RESP_OKAY;
				case (awaddr_q)
					`TPW_OFF_CTRL: begin
						if (wstrb_q[0]) begin
							ctrl_q <= wdata_q[7:0];
						end
					end
					`TPW_OFF_CNT: begin
						if (wr_low) begin
							counter_value_q <= wdata_q[15:0];
						end
					end
					`TPW_OFF_CAP: begin
						if (wr_low) begin
							capture_top_value_q <= wdata_q[15:0];
						end
					end
					`TPW_OFF_DIR: begin
						if (wstrb_q[0]) begin
							dir_q <= wdata_q[1:0];
						end
					end
					`TPW_OFF_CMPA, `TPW_OFF_CMPB, `TPW_OFF_FLAG: begin
						bresp_q <= `TPW_RESP_OKAY;
					end
					default: bresp_q <= `TPW_RESP_SLVERR;
				endcase
			end
		end
	end
	// read channel: one cycle after the address is taken
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	always @* begin
		rd_mux = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`TPW_OFF_CTRL: rd_mux = {24'h000000, ctrl_q};
			`TPW_OFF_CNT: rd_mux = {16'h0000, counter_value_q};
			`TPW_OFF_CMPA: rd_mux = {16'h0000, cmp_a_buf};
			`TPW_OFF_CMPB: rd_mux = {16'h0000, cmp_b_buf};
			`TPW_OFF_CAP: rd_mux = {16'h0000, capture_top_value_q};
			`TPW_OFF_FLAG: rd_mux = {28'h0000000, flags_q};
			`TPW_OFF_DIR: rd_mux = {30'h0000000, dir_q};
			default: rd_ok = 1'b0;
		endcase
	end
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `TPW_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_ok ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	// fast pwm loads at the top match, dual-slope at top while still counting up
	tpw_out_unit u_chan_a (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_i),
		.wr_i(wr_low && awaddr_q == `TPW_OFF_CMPA),
		.wdata_i(wdata_q[15:0]),
		.mask_i(mask),
		.load_i(at_top && (fast || up_q)),
		.buffered_i(fast || dual),
		.dual_i(dual),
		.up_i(up_q),
		.wrap_i(wrap),
		.mode_i(output_mode_a),
		.toggle_ok_i(waveform_mode_select == 4'd15),
		.dir_i(dir_q[0]),
		.count_i(counter_value_q),
		.active_o(cmp_a_act),
		.buffer_o(cmp_a_buf),
		.match_o(match_a),
		.pin_o(compare_output_a_o),
		.pin_oe_o(compare_output_a_oe_o)
	);
	tpw_out_unit u_chan_b (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_i),
		.wr_i(wr_low && awaddr_q == `TPW_OFF_CMPB),
		.wdata_i(wdata_q[15:0]),
		.mask_i(mask),
		.load_i(at_top && (fast || up_q)),
		.buffered_i(fast || dual),
		.dual_i(dual),
		.up_i(up_q),
		.wrap_i(wrap),
		.mode_i(output_mode_b),
		.toggle_ok_i(1'b0),
		.dir_i(dir_q[1]),
		.count_i(counter_value_q),
		.active_o(),
		.buffer_o(cmp_b_buf),
		.match_o(match_b),
		.pin_o(compare_output_b_o),
		.pin_oe_o(compare_output_b_oe_o)
	);
endmodule

// ==== tb/tpw_timer_props.sv ====
// port checker for the pwm timer
// assumes it is bound onto tpw_timer with one clock and a sync active-low reset
`timescale 1ns/1ps
module tpw_timer_props (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire tick_i,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire compare_output_a_o,
	input wire compare_output_a_oe_o,
	input wire compare_output_b_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	AST_RD_ANSWER: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read response late");
	AST_B_HOLD: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	AST_RESET_QUIET: assert property (disable iff (1'h0) !rst_n_i |=> !s_axi_bvalid && !s_axi_rvalid
		&& !compare_output_a_o && !compare_output_a_oe_o)
		else $error("reset did not quiet outputs");
	// waveform levels only move on timer ticks
	AST_OUT_TICK: assert property ($changed(compare_output_a_o) ||
		$changed(compare_output_b_o) |-> $past(tick_i))
		else $error("output moved without tick");
endmodule
bind tpw_timer tpw_timer_props u_props (.*);

// ==== tb/tpw_pin_model.sv ====
// port pin model for one compare output
// assumes no pull on the pad, so a released pad shows the inverse of the last driven level
`timescale 1ns/1ps
module tpw_pin_model (
	input wire ref_clk_i,
	input wire level_i,
	input wire oe_i,
	output logic pad_o
);
	logic last_q = 1'h0;
	always @(posedge ref_clk_i) begin
		if (oe_i) begin
			last_q <= level_i;
		end
	end
	assign pad_o = oe_i ? level_i : ~last_q;
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the pwm timer over axi4-lite
// assumes tick_i is bench driven, low between steps so the counter is frozen for accesses
`timescale 1ns/1ps
`include "tpw_defs.vh"
module testbench;
	logic ref_clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic tick_i = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	wire awready, wready, bvalid, arready, rvalid, out_a, oe_a, pad_a;
	wire out_b, oe_b;
	wire [1:0] bresp;
	wire [1:0] rresp;
	wire [31:0] rdata;
	logic [1:0] r;
	integer num_errors = 0;
	integer cmp_count = 0;
	integer i;
	always #12.5 ref_clk_i = ~ref_clk_i;
	tpw_timer DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tick_i(tick_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.compare_output_a_o(out_a), .compare_output_a_oe_o(oe_a),
		.compare_output_b_o(out_b), .compare_output_b_oe_o(oe_b));
	tpw_pin_model u_pin (.ref_clk_i(ref_clk_i), .level_i(out_a), .oe_i(oe_a), .pad_o(pad_a));
	task chk(input [31:0] got, input [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		@(posedge ref_clk_i);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (awvalid || wvalid || !bvalid) begin
			@(posedge ref_clk_i);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end
		bready <= 1'h0;
		chk(32'(bresp), 32'(`TPW_RESP_OKAY));
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		@(posedge ref_clk_i);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (arvalid || !rvalid) begin
			@(posedge ref_clk_i);
			if (arready) arvalid <= 1'h0;
		end
		rready <= 1'h0;
		r = rresp;
		chk(rdata, exp);
	endtask
	// n timer ticks, then settle so outputs are read away from the edge
	task step(input integer n);
		@(posedge ref_clk_i);
		tick_i <= 1'h1;
		repeat (n) @(posedge ref_clk_i);
		tick_i <= 1'h0;
		@(negedge ref_clk_i);
	endtask
	task results;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#125000;
		num_errors++;
		results;
	end
	initial begin
		repeat (6) @(posedge ref_clk_i);
		rst_n_i <= 1'h1;
		rd(`TPW_OFF_CTRL, 32'h0);
		rd(8'h1C, 32'h0);
		chk(32'(r), 32'(`TPW_RESP_SLVERR));
		wr(`TPW_OFF_CMPA, 32'h5);
		wr(`TPW_OFF_CTRL, 32'h0F);
		wr(`TPW_OFF_CNT, 32'h4);
		wr(`TPW_OFF_FLAG, 32'hF);
		wr(`TPW_OFF_CMPA, 32'h8);
		step(2);
		rd(`TPW_OFF_CNT, 32'h0);
		rd(`TPW_OFF_FLAG, 32'h3);
		step(8);
		rd(`TPW_OFF_CNT, 32'h8);
		step(1);
		rd(`TPW_OFF_CNT, 32'h0);
		wr(`TPW_OFF_CTRL, 32'h0E);
		wr(`TPW_OFF_CAP, 32'h3);
		wr(`TPW_OFF_CNT, 32'h2);
		step(2);
		rd(`TPW_OFF_CNT, 32'h0);
		wr(`TPW_OFF_CNT, 32'h10);
		step(1);
		rd(`TPW_OFF_CNT, 32'h11);
		wr(`TPW_OFF_CNT, 32'hFFFF);
		step(1);
		rd(`TPW_OFF_CNT, 32'h0);
		wr(`TPW_OFF_CTRL, 32'h0);
		wr(`TPW_OFF_CMPA, 32'h4);
		// top is set before counting starts and left alone while it runs
		wr(`TPW_OFF_CTRL, 32'h0B);
		wr(`TPW_OFF_CNT, 32'h3);
		wr(`TPW_OFF_FLAG, 32'hF);
		step(2);
		rd(`TPW_OFF_CNT, 32'h3);
		step(4);
		rd(`TPW_OFF_CNT, 32'h1);
		rd(`TPW_OFF_FLAG, 32'h7);
		wr(`TPW_OFF_CTRL, 32'h0);
		wr(`TPW_OFF_CMPA, 32'h2);
		wr(`TPW_OFF_DIR, 32'h3);
		for (i = 0; i < 2; i++) begin
			// channel b keeps compare 0, so it shows the one-cycle spike
			wr(`TPW_OFF_CTRL, i ? 32'hF5 : 32'hA5);
			wr(`TPW_OFF_CNT, 32'hFE);
			chk(32'({oe_a, oe_b}), 32'h3);
			step(2);
			chk(32'(pad_a), 32'(1 - i));
			chk(32'(out_b), 32'(1 - i));
			step(3);
			chk(32'(pad_a), 32'(i));
			chk(32'(out_b), 32'(i));
		end
		// toggle on the top-defining compare gives a square wave of two periods
		wr(`TPW_OFF_CTRL, 32'h0);
		wr(`TPW_OFF_CMPA, 32'h3);
		wr(`TPW_OFF_CTRL, 32'h1F);
		wr(`TPW_OFF_CNT, 32'h0);
		r[0] = pad_a;
		step(4);
		chk(32'(pad_a), 32'(!r[0]));
		step(4);
		chk(32'(pad_a), 32'(r[0]));
		// dual slope on capture top 3, compare 2, non-inverted
		wr(`TPW_OFF_CTRL, 32'h0);
		wr(`TPW_OFF_CMPA, 32'h2);
		wr(`TPW_OFF_CNT, 32'h0);
		wr(`TPW_OFF_CTRL, 32'h2A);
		step(3);
		chk(32'(pad_a), 32'h0);
		step(3);
		chk(32'(pad_a), 32'h1);
		wr(`TPW_OFF_DIR, 32'h0);
		chk(32'({oe_a, oe_b}), 32'h0);
		// fixed tops: 5,6,7 then 1,2,3, widths 8,9,10 bits
		for (i = 0; i < 6; i++) begin
			wr(`TPW_OFF_CTRL, (i < 3) ? i + 5 : i - 2);
			wr(`TPW_OFF_CMPB, 32'hFFFF);
			rd(`TPW_OFF_CMPB, 32'((16'h0100 << (i % 3)) - 16'h0001));
		end
		results;
	end
endmodule
